// File: include/strobe_slot_pkg.sv
// Purpose: shared constants, types and decoding for the rail strobe assignment block
// Assumes: 40 MHz device clock, 8-bit register port
// Notes: rail index order is fixed by RAIL_* below
package strobe_slot_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_RAILS = 6;
   localparam int STROBE_W = 4;
   localparam int NUM_GAPS = 9;
   localparam int GAP_CNT_W = 21;

   localparam logic [ADDR_W-1:0] BUCK_PAIR_OFS = 8'h23;
   localparam logic [ADDR_W-1:0] BACKUP_OFS = 8'h24;
   localparam logic [ADDR_W-1:0] SWITCH_REG_OFS = 8'h25;
   localparam logic [ADDR_W-1:0] OUTPUT_PIN_OFS = 8'h26;

   localparam logic [DATA_W-1:0] BUCK_PAIR_RST = 8'h84;
   localparam logic [DATA_W-1:0] BACKUP_RST = 8'h10;
   localparam logic [DATA_W-1:0] SWITCH_REG_RST = 8'h88;
   localparam logic [DATA_W-1:0] OUTPUT_PIN_RST = 8'h08;
   // writable bits of the backup register: 5-4 and 1-0
   localparam logic [DATA_W-1:0] BACKUP_WMASK = 8'h33;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

   localparam int HI_LSB = 4;
   localparam int BK6_LSB = 4;
   localparam int BK5_LSB = 0;
   localparam int LO_LSB = 0;
   localparam int BK_FIELD_W = 2;

   localparam logic [STROBE_W-1:0] FIRST_STROBE = 4'h1;
   localparam logic [STROBE_W-1:0] SEALED_FIRST_STROBE = 4'h3;
   localparam logic [STROBE_W-1:0] LAST_STROBE = 4'ha;
   localparam logic [STROBE_W-1:0] NO_STROBE = 4'h0;
   localparam logic [STROBE_W-1:0] BACKUP_CODE_LO = 4'h1;
   localparam logic [STROBE_W-1:0] BACKUP_CODE_HI = 4'h2;

   localparam int RAIL_BUCK4 = 0;
   localparam int RAIL_BUCK3 = 1;
   localparam int RAIL_BACKUP6 = 2;
   localparam int RAIL_BACKUP5 = 3;
   localparam int RAIL_SWITCH = 4;
   localparam int RAIL_REGULATOR = 5;
   localparam logic [NUM_RAILS-1:0] BACKUP_RAILS = 6'h0c;

   localparam longint CLK_HZ = 40_000_000;
   localparam longint GAP_SHORT_MS = 2;
   localparam longint GAP_LONG_MS = 5;
   localparam longint DOWN_FACTOR = 10;
   localparam longint SHORT_GAP_CYC = CLK_HZ / 1000 * GAP_SHORT_MS;
   localparam longint LONG_GAP_CYC = CLK_HZ / 1000 * GAP_LONG_MS;

   typedef struct packed {
      logic valid;
      logic up;
      logic [STROBE_W-1:0] num;
   } strobe_evt_t;

   typedef enum {SEQ_IDLE, SEQ_STROBE, SEQ_WAIT} seq_state_t;

   // strobe at which a field enables its rail, NO_STROBE when unsequenced
   function automatic logic [STROBE_W-1:0] strobe_of(input logic [STROBE_W-1:0] code,
                                                      input logic isBackup);
      logic [STROBE_W-1:0] s;
      s = NO_STROBE;
      if (isBackup)
      begin
         if (code == BACKUP_CODE_LO || code == BACKUP_CODE_HI)
            s = code;
      end
      else if (code >= SEALED_FIRST_STROBE && code <= LAST_STROBE)
         s = code;
      return s;
   endfunction : strobe_of

endpackage : strobe_slot_pkg

// File: core/gap_timer.sv
// Purpose: one-shot down counter timing the gap between two strobes
// Assumes: loadValue is at least one cycle
// Notes: done pulses exactly loadValue cycles after load
`timescale 1ns/1ps
module gap_timer
   import strobe_slot_pkg::*;
#(
   parameter int CNT_W = GAP_CNT_W
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [CNT_W-1:0] loadValue,
   output logic done
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] elapsed_reg;
   logic [CNT_W-1:0] loaded_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         count_reg <= '0;
      else if (load)
         count_reg <= loadValue;
      else if (count_reg != '0)
         count_reg <= count_reg - 1'b1;
   end

   always_comb
   begin
      done = (count_reg == {{(CNT_W-1){1'b0}}, 1'b1}) && !load;
   end

   // helper for checking only
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         elapsed_reg <= '0;
         loaded_reg <= '0;
      end
      else if (load)
      begin
         elapsed_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
         loaded_reg <= loadValue;
      end
      else
         elapsed_reg <= elapsed_reg + 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_gap_exact_len: assert property (done |-> elapsed_reg == loaded_reg)
      else $error("gap timer ended at the wrong count");

endmodule : gap_timer

// File: core/rail_enable_ctrl.sv
// Purpose: per-rail enable state driven by strobe events and strobe fields
// Assumes: one strobe event at most per cycle
// Notes: backup rails stay on once the seal is broken
`timescale 1ns/1ps
module rail_enable_ctrl
   import strobe_slot_pkg::*;
#(
   parameter int N = NUM_RAILS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input strobe_evt_t evt,
   input wire logic [N-1:0][STROBE_W-1:0] slotCodes,
   input wire logic [N-1:0] backupMask,
   input wire logic sealBroken,
   output logic [N-1:0] railEnable
);

   logic [N-1:0][STROBE_W-1:0] slotStrobe;

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_rail
         assign slotStrobe[i] = strobe_of(slotCodes[i], backupMask[i]);

         // unsequenced codes never match: strobe numbers start at one
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               railEnable[i] <= 1'b0;
            else if (evt.valid && slotStrobe[i] == evt.num && slotStrobe[i] != NO_STROBE)
            begin
               if (evt.up)
                  railEnable[i] <= 1'b1;
               else if (!(backupMask[i] && sealBroken))
                  railEnable[i] <= 1'b0;
            end
         end

         a_strobe_turns_on: assert property (@(posedge clk) disable iff (sys_rst)
            evt.valid && evt.up && slotStrobe[i] == evt.num && evt.num != NO_STROBE
            |=> railEnable[i])
            else $error("rail not enabled at its strobe");

         a_unsequenced_still: assert property (@(posedge clk) disable iff (sys_rst)
            slotStrobe[i] == NO_STROBE && $stable(slotCodes[i]) |=> $stable(railEnable[i]))
            else $error("unsequenced rail changed state");

         a_backup_kept_on: assert property (@(posedge clk) disable iff (sys_rst)
            backupMask[i] && sealBroken && railEnable[i] |=> railEnable[i])
            else $error("backup rail switched off after seal broken");
      end
   endgenerate

endmodule : rail_enable_ctrl

// File: core/rail_strobe_assignment.sv
// Purpose: strobe slot registers and the power-up/power-down strobe walk
// Assumes: register port is a plain synchronous strobe interface
// Notes: gap delay bits, delay factor and seal flag come from outside
//
// How it works
// - buck pair register at 0x23, resets 0x84
// - codes 3h-Ah enable at strobes 3-10
// - other four-bit codes leave rail unsequenced
// - backup register at 0x24, resets 0x10
// - backup codes 1h,2h strobe one,two; others none
// - strobes one and two only when unsealed
// - broken seal: backup rails never switched off
// - switch/regulator register at 0x25, resets 0x88
// - output pin register at 0x26, resets 0x08
// - gap between strobes is 2 or 5 ms
// - delay factor multiplies power-down gaps by ten
`timescale 1ns/1ps
module rail_strobe_assignment
   import strobe_slot_pkg::*;
#(
   parameter int CNT_W = GAP_CNT_W,
   parameter logic [GAP_CNT_W-1:0] SHORT_GAP_CYCLES = GAP_CNT_W'(SHORT_GAP_CYC),
   parameter logic [GAP_CNT_W-1:0] LONG_GAP_CYCLES = GAP_CNT_W'(LONG_GAP_CYC)
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic writeUnlocked,
   output logic [DATA_W-1:0] readData,
   output logic readValid,
   input wire logic [NUM_GAPS-1:0] gapDelaySel,
   input wire logic power_down_delay_factor,
   input wire logic backup_seal_flag,
   input wire logic powerUpReq,
   input wire logic powerDownReq,
   output logic [NUM_RAILS-1:0] railEnable,
   output logic [STROBE_W-1:0] activeStrobe,
   output logic seqBusy,
   output logic seqDone
);

   logic [DATA_W-1:0] buckPair_reg;
   logic [DATA_W-1:0] backup_reg;
   logic [DATA_W-1:0] switchReg_reg;
   logic [DATA_W-1:0] outputPin_reg;
   logic [DATA_W-1:0] readData_reg;
   logic readValid_reg;
   logic [DATA_W-1:0] readData_next;
   logic writeOk;

   seq_state_t state_reg;
   logic up_reg;
   logic sealLatched_reg;
   logic [STROBE_W-1:0] strobe_reg;
   logic seqDone_reg;
   logic [STROBE_W-1:0] lowStrobe;
   logic lastStrobe;
   logic timerLoad;
   logic timerDone;
   logic gapLong;
   logic [CNT_W-1:0] baseGap;
   logic [CNT_W-1:0] gapCycles;
   strobe_evt_t evt;
   logic [NUM_RAILS-1:0][STROBE_W-1:0] slotCodes;

   // register writes are dropped silently while the password is not satisfied
   always_comb
   begin
      writeOk = regWrite && writeUnlocked;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         buckPair_reg <= BUCK_PAIR_RST;
         backup_reg <= BACKUP_RST;
         switchReg_reg <= SWITCH_REG_RST;
         outputPin_reg <= OUTPUT_PIN_RST;
      end
      else if (writeOk)
      begin
         if (regAddr == BUCK_PAIR_OFS)
            buckPair_reg <= regWdata;
         else if (regAddr == BACKUP_OFS)
            backup_reg <= regWdata & BACKUP_WMASK;
         else if (regAddr == SWITCH_REG_OFS)
            switchReg_reg <= regWdata;
         else if (regAddr == OUTPUT_PIN_OFS)
            outputPin_reg <= regWdata;
      end
   end

   always_comb
   begin
      if (regAddr == BUCK_PAIR_OFS)
         readData_next = buckPair_reg;
      else if (regAddr == BACKUP_OFS)
         readData_next = backup_reg;
      else if (regAddr == SWITCH_REG_OFS)
         readData_next = switchReg_reg;
      else if (regAddr == OUTPUT_PIN_OFS)
         readData_next = outputPin_reg;
      else
         readData_next = READ_UNMAPPED;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         readData_reg <= '0;
         readValid_reg <= 1'b0;
      end
      else
      begin
         readValid_reg <= regRead;
         if (regRead)
            readData_reg <= readData_next;
      end
   end

   assign readData = readData_reg;
   assign readValid = readValid_reg;

   always_comb
   begin
      slotCodes[RAIL_BUCK4] = buckPair_reg[HI_LSB +: STROBE_W];
      slotCodes[RAIL_BUCK3] = buckPair_reg[LO_LSB +: STROBE_W];
      slotCodes[RAIL_BACKUP6] = STROBE_W'(backup_reg[BK6_LSB +: BK_FIELD_W]);
      slotCodes[RAIL_BACKUP5] = STROBE_W'(backup_reg[BK5_LSB +: BK_FIELD_W]);
      slotCodes[RAIL_SWITCH] = switchReg_reg[HI_LSB +: STROBE_W];
      slotCodes[RAIL_REGULATOR] = switchReg_reg[LO_LSB +: STROBE_W];
   end

   // strobe walk: up runs low to ten, down runs ten back to low
   always_comb
   begin
      lowStrobe = sealLatched_reg ? SEALED_FIRST_STROBE : FIRST_STROBE;
      lastStrobe = up_reg ? (strobe_reg == LAST_STROBE) : (strobe_reg == lowStrobe);
      evt.valid = (state_reg == SEQ_STROBE);
      evt.up = up_reg;
      evt.num = strobe_reg;
      timerLoad = (state_reg == SEQ_STROBE) && !lastStrobe;
   end

   // gap k sits between strobe k and k+1; bit 0 selects gap one
   // index runs off the ends at strobe ten going up and strobe one going down; only read while loading
   always_comb
   begin
      if (up_reg)
         gapLong = gapDelaySel[strobe_reg - FIRST_STROBE];
      else
         gapLong = gapDelaySel[strobe_reg - FIRST_STROBE - 1'b1];
      baseGap = gapLong ? LONG_GAP_CYCLES : SHORT_GAP_CYCLES;
      if (!up_reg && power_down_delay_factor)
         gapCycles = CNT_W'(baseGap * CNT_W'(DOWN_FACTOR));
      else
         gapCycles = baseGap;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= SEQ_IDLE;
         up_reg <= 1'b1;
         sealLatched_reg <= 1'b0;
         strobe_reg <= NO_STROBE;
      end
      else
      begin
         case (state_reg)
            SEQ_IDLE:
            begin
               // seal state is frozen for the whole walk so the range is stable
               if (powerUpReq)
               begin
                  up_reg <= 1'b1;
                  sealLatched_reg <= backup_seal_flag;
                  strobe_reg <= backup_seal_flag ? SEALED_FIRST_STROBE : FIRST_STROBE;
                  state_reg <= SEQ_STROBE;
               end
               else if (powerDownReq)
               begin
                  up_reg <= 1'b0;
                  sealLatched_reg <= backup_seal_flag;
                  strobe_reg <= LAST_STROBE;
                  state_reg <= SEQ_STROBE;
               end
            end
            SEQ_STROBE:
            begin
               if (lastStrobe)
                  state_reg <= SEQ_IDLE;
               else
                  state_reg <= SEQ_WAIT;
            end
            SEQ_WAIT:
            begin
               if (timerDone)
               begin
                  strobe_reg <= up_reg ? strobe_reg + 1'b1 : strobe_reg - 1'b1;
                  state_reg <= SEQ_STROBE;
               end
            end
            default:
               state_reg <= SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         seqDone_reg <= 1'b0;
      else
         seqDone_reg <= (state_reg == SEQ_STROBE) && lastStrobe;
   end

   assign seqDone = seqDone_reg;
   assign seqBusy = (state_reg != SEQ_IDLE);
   assign activeStrobe = strobe_reg;

   gap_timer #(
      .CNT_W(CNT_W)
   ) u_gap_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(timerLoad),
      .loadValue(gapCycles),
      .done(timerDone)
   );

   rail_enable_ctrl #(
      .N(NUM_RAILS)
   ) u_rail_ctrl (
      .clk(clk),
      .sys_rst(sys_rst),
      .evt(evt),
      .slotCodes(slotCodes),
      .backupMask(BACKUP_RAILS),
      .sealBroken(backup_seal_flag),
      .railEnable(railEnable)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_strobe_step;
      state_reg == SEQ_STROBE && !lastStrobe;
   endsequence

   sequence s_wait_phase;
      state_reg == SEQ_WAIT;
   endsequence

   sequence s_up_request;
      state_reg == SEQ_IDLE && powerUpReq;
   endsequence

   sequence s_final_strobe;
      state_reg == SEQ_STROBE && lastStrobe;
   endsequence

   a_locked_write_drop: assert property (regWrite && !writeUnlocked
      |=> $stable(buckPair_reg) && $stable(backup_reg) && $stable(switchReg_reg)
          && $stable(outputPin_reg))
      else $error("register changed on a locked write");

   a_buck_pair_write: assert property (writeOk && regAddr == BUCK_PAIR_OFS
      |=> buckPair_reg == $past(regWdata))
      else $error("buck pair register did not take the write");

   a_switch_reg_write: assert property (writeOk && regAddr == SWITCH_REG_OFS
      |=> switchReg_reg == $past(regWdata))
      else $error("switch and regulator register did not take the write");

   a_pin_reg_write: assert property (writeOk && regAddr == OUTPUT_PIN_OFS
      |=> outputPin_reg == $past(regWdata))
      else $error("output pin register did not take the write");

   a_backup_reserved: assert property ((backup_reg & ~BACKUP_WMASK) == '0)
      else $error("backup reserved bits not zero");

   a_sealed_skip_low: assert property (evt.valid && sealLatched_reg
      |-> evt.num >= SEALED_FIRST_STROBE)
      else $error("strobe one or two run while sealed");

   a_up_start_strobe: assert property (s_up_request
      |=> evt.valid
          && evt.num == ($past(backup_seal_flag) ? SEALED_FIRST_STROBE : FIRST_STROBE))
      else $error("power-up walk started at the wrong strobe");

   a_step_then_wait: assert property (s_strobe_step |=> s_wait_phase)
      else $error("strobe not followed by a gap");

   a_walk_end_done: assert property (s_final_strobe |=> seqDone && !seqBusy)
      else $error("walk did not end after its last strobe");

   a_down_gap_scaled: assert property (timerLoad && !up_reg && power_down_delay_factor
      |-> gapCycles == CNT_W'(baseGap * CNT_W'(DOWN_FACTOR)))
      else $error("power-down gap not scaled by ten");

   a_up_gap_plain: assert property (timerLoad && up_reg
      |-> gapCycles == (gapLong ? LONG_GAP_CYCLES : SHORT_GAP_CYCLES))
      else $error("power-up gap affected by delay factor");

endmodule : rail_strobe_assignment

// File: bench/tb_top.sv
// Purpose: self-checking bench for the rail strobe assignment block
// Assumes: gap counts shortened to 4 and 10 cycles
// Notes: inputs change on the falling clock edge only
`timescale 1ns/1ps
module tb_top
   import strobe_slot_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [DATA_W-1:0] regWdata = 8'h00;
   logic writeUnlocked = 1'b0;
   logic [NUM_GAPS-1:0] gapDelaySel = 9'h001;
   logic power_down_delay_factor = 1'b0;
   logic backup_seal_flag = 1'b0;
   logic powerUpReq = 1'b0;
   logic powerDownReq = 1'b0;
   logic [DATA_W-1:0] readData;
   logic readValid;
   logic [NUM_RAILS-1:0] railEnable;
   logic [STROBE_W-1:0] activeStrobe;
   logic seqBusy;
   logic seqDone;
   int miscompares = 0;
   int compares = 0;

   always #12.5 clk = ~clk;

   rail_strobe_assignment #(
      .CNT_W(GAP_CNT_W),
      .SHORT_GAP_CYCLES(21'h4),
      .LONG_GAP_CYCLES(21'ha)
   ) DUT (
      .clk(clk),
      .sys_rst(sys_rst),
      .regWrite(regWrite),
      .regRead(regRead),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .writeUnlocked(writeUnlocked),
      .readData(readData),
      .readValid(readValid),
      .gapDelaySel(gapDelaySel),
      .power_down_delay_factor(power_down_delay_factor),
      .backup_seal_flag(backup_seal_flag),
      .powerUpReq(powerUpReq),
      .powerDownReq(powerDownReq),
      .railEnable(railEnable),
      .activeStrobe(activeStrobe),
      .seqBusy(seqBusy),
      .seqDone(seqDone)
   );

   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      writeUnlocked = unl;
      @(negedge clk);
      regWrite = 1'b0;
      writeUnlocked = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      chk("readValid", {7'h00, readValid}, 8'h01);
      chk("readData", readData, exp);
   endtask : rd

   // bounded: a stuck walk ends the run instead of hanging it
   task automatic wait_strobe(input logic [3:0] s, output int n);
      n = 0;
      while (activeStrobe !== s)
      begin
         @(negedge clk);
         n++;
         if (n > 3000)
         begin
            miscompares++;
            $display("BAD activeStrobe expected %h seen timeout", s);
            final_report();
         end
      end
   endtask : wait_strobe

   task automatic wait_idle();
      int n;
      n = 0;
      while (seqBusy !== 1'b0)
      begin
         @(negedge clk);
         n++;
         if (n > 3000)
         begin
            miscompares++;
            $display("BAD seqBusy expected 0 seen timeout");
            final_report();
         end
      end
      // done pulses only in the first idle cycle
      chk("seqDone", {7'h00, seqDone}, 8'h01);
      @(negedge clk);
      chk("seqDone gone", {7'h00, seqDone}, 8'h00);
   endtask : wait_idle

   task automatic kick(input logic up);
      @(negedge clk);
      if (up)
         powerUpReq = 1'b1;
      else
         powerDownReq = 1'b1;
      @(negedge clk);
      powerUpReq = 1'b0;
      powerDownReq = 1'b0;
   endtask : kick

   task automatic t_regs();
      rd(8'h23, 8'h84);
      rd(8'h24, 8'h10);
      rd(8'h25, 8'h88);
      rd(8'h26, 8'h08);
      rd(8'h27, 8'h00);
      wr(8'h23, 8'h55, 1'b0);
      rd(8'h23, 8'h84);
      wr(8'h24, 8'hff, 1'b1);
      rd(8'h24, 8'h33);
      wr(8'h26, 8'h5a, 1'b1);
      rd(8'h26, 8'h5a);
      // buck4 at 3, buck3 at 10, backup6 at 2, backup5 at 1, switch off-list, regulator at 5
      wr(8'h23, 8'h3a, 1'b1);
      wr(8'h24, 8'h21, 1'b1);
      wr(8'h25, 8'hb5, 1'b1);
      rd(8'h23, 8'h3a);
      rd(8'h25, 8'hb5);
      $display("test registers done");
   endtask : t_regs

   task automatic t_up();
      int n;
      kick(1'b1);
      chk("activeStrobe", {4'h0, activeStrobe}, 8'h01);
      wait_strobe(4'h2, n);
      chk("long gap", 8'(n), 8'h0b);
      chk("railEnable s2", {2'h0, railEnable}, 8'h08);
      wait_strobe(4'h3, n);
      chk("short gap", 8'(n), 8'h05);
      chk("railEnable s3", {2'h0, railEnable}, 8'h0c);
      wait_strobe(4'h4, n);
      chk("railEnable s4", {2'h0, railEnable}, 8'h0d);
      wait_idle();
      chk("railEnable up", {2'h0, railEnable}, 8'h2f);
      $display("test power up done");
   endtask : t_up

   task automatic t_down_sealed();
      backup_seal_flag = 1'b1;
      kick(1'b0);
      wait_idle();
      // backup rails must survive a down walk once the seal is gone
      chk("railEnable sealed down", {2'h0, railEnable}, 8'h0c);
      chk("sealed down stop", {4'h0, activeStrobe}, 8'h03);
      $display("test sealed power down done");
   endtask : t_down_sealed

   task automatic t_down_factor();
      int n;
      backup_seal_flag = 1'b0;
      power_down_delay_factor = 1'b1;
      kick(1'b0);
      chk("activeStrobe down", {4'h0, activeStrobe}, 8'h0a);
      wait_strobe(4'h9, n);
      chk("scaled gap", 8'(n), 8'h29);
      wait_idle();
      chk("railEnable down", {2'h0, railEnable}, 8'h00);
      $display("test scaled power down done");
   endtask : t_down_factor

   task automatic t_up_sealed();
      int n;
      power_down_delay_factor = 1'b0;
      backup_seal_flag = 1'b1;
      kick(1'b1);
      chk("sealed first strobe", {4'h0, activeStrobe}, 8'h03);
      wait_strobe(4'h4, n);
      // factor is off here, so strobe three to four is the plain short gap
      chk("up gap", 8'(n), 8'h05);
      wait_idle();
      chk("railEnable sealed up", {2'h0, railEnable}, 8'h23);
      backup_seal_flag = 1'b0;
      $display("test sealed power up done");
   endtask : t_up_sealed

   task automatic t_seal_mid_down();
      int n;
      kick(1'b1);
      wait_idle();
      chk("railEnable relit", {2'h0, railEnable}, 8'h2f);
      kick(1'b0);
      wait_strobe(4'h3, n);
      // seal breaks mid-walk: strobes two and one still run but must spare the backups
      backup_seal_flag = 1'b1;
      wait_idle();
      chk("railEnable seal mid down", {2'h0, railEnable}, 8'h0c);
      chk("last down strobe", {4'h0, activeStrobe}, 8'h01);
      backup_seal_flag = 1'b0;
      $display("test seal broken mid walk done");
   endtask : t_seal_mid_down

   initial
   begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      chk("railEnable reset", {2'h0, railEnable}, 8'h00);
      t_regs();
      t_up();
      t_down_sealed();
      t_down_factor();
      t_up_sealed();
      t_seal_mid_down();
      final_report();
   end
endmodule : tb_top
